// ==== rtl/tct_map.vh ====
/*
  Constants for the three channel interval timer: port codes, control word
  field positions, byte access codes and pattern codes.
  Assumes it is included by the timer module only.
*/
`ifndef TCT_MAP_VH
`define TCT_MAP_VH

// Port select codes.
`define TCT_PORT_SETUP 2'h3
`define TCT_PORT_NONE 2'h3

// Control word field positions.
`define TCT_CW_CHAN_HI 7
`define TCT_CW_CHAN_LO 6
`define TCT_CW_ACC_HI 5
`define TCT_CW_ACC_LO 4
`define TCT_CW_PAT_HI 3
`define TCT_CW_PAT_LO 1
`define TCT_CW_DEC 0

// Byte access codes.
`define TCT_ACC_LATCH 2'h0
`define TCT_ACC_LOW 2'h1
`define TCT_ACC_HIGH 2'h2
`define TCT_ACC_BOTH 2'h3

// Operating pattern codes after folding the ignored top bit.
`define TCT_PAT_TERM 3'h0
`define TCT_PAT_SHOT 3'h1
`define TCT_PAT_RATE 3'h2
`define TCT_PAT_SQUARE 3'h3
`define TCT_PAT_SSTROBE 3'h4
`define TCT_PAT_HSTROBE 3'h5

// Count values and reset values.
`define TCT_ONE 16'h0001
`define TCT_TWO 16'h0002
`define TCT_ZERO16 16'h0000
`define TCT_BYTE0 8'h00
`define TCT_SYNC_IDLE 19'h7FFFF
`define TCT_SYNC_W 19

`endif

// ==== rtl/tct_timer.v ====
/*
  Three channel interval timer: a byte wide processor port with select,
  read and write strobes and two port select lines, a write-only setup word
  and three 16-bit presettable down counters with own clock, gate and output.
  Assumes every pin is asynchronous to clk, and that the channel clocks and
  strobes are slow enough to be seen after a two stage synchroniser at 20 MHz.
  The data pin is split into input, output and an active low output enable.
*/
`timescale 1ns/100ps
`include "tct_map.vh"

module tct_timer (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Processor port.
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire port_select_lo,
  input wire port_select_hi,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n,
  // Channel pins.
  input wire [2:0] cnt_clk,
  input wire [2:0] cnt_gate,
  output reg [2:0] cnt_out
);

  // Decrement by one, binary or four decimal digits with borrow.
  function [15:0] tct_dec1;
    input [15:0] v;
    input dec;
    integer k;
    reg borrow;
    reg [3:0] d;
    begin
      tct_dec1 = v - `TCT_ONE;
      borrow = 1'b1;
      if (dec) begin
        for (k = 0; k < 4; k = k + 1) begin
          d = v[4*k +: 4];
          if (borrow && d == 4'h0) begin
            d = 4'h9;
          end else if (borrow) begin
            d = d - 4'h1;
            borrow = 1'b0;
          end
          tct_dec1[4*k +: 4] = d;
        end
      end
    end
  endfunction

  // Decrement by n (1 to 3) steps.
  function [15:0] tct_decn;
    input [15:0] v;
    input dec;
    input [1:0] n;
    integer k;
    begin
      tct_decn = v;
      for (k = 0; k < 3; k = k + 1) begin
        if (k < n) begin
          tct_decn = tct_dec1(tct_decn, dec);
        end
      end
    end
  endfunction

  // Two stage synchroniser plus an edge stage fed only by the second stage.
  reg [18:0] sync1;
  reg [18:0] sync2;
  reg [18:0] sync3;
  wire [18:0] pins_raw;
  assign pins_raw = {cnt_gate, cnt_clk, data_in, port_select_hi, port_select_lo,
    cs_n, rd_n, wr_n};

  always @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= `TCT_SYNC_IDLE;
      sync2 <= `TCT_SYNC_IDLE;
      sync3 <= `TCT_SYNC_IDLE;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Synchronised views.
  wire s_wr_n = sync2[0];
  wire s_rd_n = sync2[1];
  wire s_cs_n = sync2[2];
  wire [1:0] s_port = sync2[4:3];
  wire [7:0] s_data = sync2[12:5];
  wire [2:0] ck_rise = sync2[15:13] & ~sync3[15:13];
  wire [2:0] ck_fall = ~sync2[15:13] & sync3[15:13];
  wire [2:0] s_gate = sync2[18:16];
  wire [2:0] gate_rise = sync2[18:16] & ~sync3[18:16];

  // Write held while the strobe is low; acted on when it ends.
  reg [7:0] wr_data;
  reg [1:0] wr_port;
  reg wr_live;
  reg rd_live;
  reg [1:0] rd_port;
  wire wr_end = wr_live && s_wr_n;
  wire rd_end = rd_live && s_rd_n;

  // Per channel state.
  reg [15:0] cnt [0:2];
  reg [15:0] reload [0:2];
  reg [15:0] hold [0:2];
  reg [2:0] pat [0:2];
  reg [1:0] acc [0:2];
  reg [2:0] dec;
  reg [2:0] held;
  reg [2:0] wptr;
  reg [2:0] rptr;
  reg [2:0] pend;
  reg [2:0] pend_rise;
  reg [2:0] run;
  reg [2:0] trig;
  integer i;

  // Strobe capture; a deselected device never opens a transfer.
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_live <= 1'b0;
      rd_live <= 1'b0;
      wr_data <= `TCT_BYTE0;
      wr_port <= `TCT_PORT_NONE;
      rd_port <= `TCT_PORT_NONE;
    end else begin
      wr_live <= !s_cs_n && !s_wr_n && s_rd_n;
      rd_live <= !s_cs_n && !s_rd_n && s_wr_n;
      if (!s_cs_n && !s_wr_n) begin
        wr_data <= s_data;
        wr_port <= s_port;
      end
      if (!s_cs_n && !s_rd_n) begin
        rd_port <= s_port;
      end
    end
  end

  // Read data path and enable; floats unless a channel read is active.
  reg [15:0] rd_word;
  reg rd_upper;
  always @* begin
    rd_word = `TCT_ZERO16;
    rd_upper = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      if (s_port == i) begin
        rd_word = held[i] ? hold[i] : cnt[i];
        rd_upper = acc[i] == `TCT_ACC_HIGH || (acc[i] == `TCT_ACC_BOTH && rptr[i]);
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      data_out <= `TCT_BYTE0;
      data_oe_n <= 1'b1;
    end else begin
      // byte port drives only on channel reads
      data_oe_n <= !(!s_cs_n && !s_rd_n && s_wr_n && s_port != `TCT_PORT_SETUP);
      data_out <= rd_upper ? rd_word[15:8] : rd_word[7:0];
    end
  end

  // Channels: setup, loading, latching and counting.
  always @(posedge clk) begin
    if (sys_rst) begin
      dec <= 3'h0;
      held <= 3'h0;
      wptr <= 3'h0;
      rptr <= 3'h0;
      pend <= 3'h0;
      pend_rise <= 3'h0;
      run <= 3'h0;
      trig <= 3'h0;
      cnt_out <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        cnt[i] <= `TCT_ZERO16;
        reload[i] <= `TCT_ZERO16;
        hold[i] <= `TCT_ZERO16;
        pat[i] <= `TCT_PAT_TERM;
        acc[i] <= `TCT_ACC_BOTH;
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_end && wr_port == `TCT_PORT_SETUP &&
            wr_data[`TCT_CW_CHAN_HI:`TCT_CW_CHAN_LO] == i) begin
          if (wr_data[`TCT_CW_ACC_HI:`TCT_CW_ACC_LO] == `TCT_ACC_LATCH) begin
            hold[i] <= cnt[i];
            held[i] <= 1'b1;
          end else begin
            acc[i] <= wr_data[`TCT_CW_ACC_HI:`TCT_CW_ACC_LO];
            pat[i] <= wr_data[`TCT_CW_PAT_LO+1] ?
              {1'b0, wr_data[`TCT_CW_PAT_LO+1:`TCT_CW_PAT_LO]} :
              wr_data[`TCT_CW_PAT_HI:`TCT_CW_PAT_LO];
            dec[i] <= wr_data[`TCT_CW_DEC];
            wptr[i] <= 1'b0;
            rptr[i] <= 1'b0;
            held[i] <= 1'b0;
            pend[i] <= 1'b0;
            pend_rise[i] <= 1'b0;
            run[i] <= 1'b0;
            trig[i] <= 1'b0;
            cnt_out[i] <= wr_data[`TCT_CW_PAT_HI:`TCT_CW_PAT_LO] != `TCT_PAT_TERM;
          end
        end else if (wr_end && wr_port == i) begin
          if (acc[i] == `TCT_ACC_LOW) begin
            reload[i] <= {`TCT_BYTE0, wr_data};
            pend[i] <= 1'b1;
          end else if (acc[i] == `TCT_ACC_HIGH) begin
            reload[i] <= {wr_data, `TCT_BYTE0};
            pend[i] <= 1'b1;
          end else if (!wptr[i]) begin
            reload[i][7:0] <= wr_data;
            wptr[i] <= 1'b1;
            if (pat[i] == `TCT_PAT_TERM) begin
              run[i] <= 1'b0;
            end
          end else begin
            reload[i][15:8] <= wr_data;
            wptr[i] <= 1'b0;
            pend[i] <= 1'b1;
          end
        end
        // read advances pointer and last byte frees latch
        if (rd_end && rd_port == i) begin
          if (acc[i] == `TCT_ACC_BOTH) begin
            rptr[i] <= !rptr[i];
          end
          if (acc[i] != `TCT_ACC_BOTH || rptr[i]) begin
            held[i] <= 1'b0;
          end
        end
        // Gate rise arms a trigger for the next channel clock fall.
        if (gate_rise[i]) begin
          trig[i] <= 1'b1;
        end
        // loading waits for a rise then a fall
        if (pend[i] && ck_rise[i]) begin
          pend_rise[i] <= 1'b1;
        end
        if (ck_fall[i]) begin
          if (pend_rise[i]) begin
            pend[i] <= 1'b0;
            pend_rise[i] <= 1'b0;
            if (pat[i] == `TCT_PAT_TERM || pat[i] == `TCT_PAT_SSTROBE || !run[i]) begin
              if (pat[i] != `TCT_PAT_SHOT && pat[i] != `TCT_PAT_HSTROBE) begin
                cnt[i] <= reload[i];
                run[i] <= 1'b1;
                cnt_out[i] <= pat[i] != `TCT_PAT_TERM;
              end
            end
          end else if (trig[i] && pat[i] != `TCT_PAT_TERM &&
                       pat[i] != `TCT_PAT_SSTROBE) begin
            trig[i] <= 1'b0;
            cnt[i] <= reload[i];
            run[i] <= 1'b1;
            cnt_out[i] <= pat[i] != `TCT_PAT_SHOT;
          end else if (run[i]) begin
            case (pat[i])
              `TCT_PAT_TERM: begin
                if (s_gate[i]) begin
                  cnt[i] <= tct_dec1(cnt[i], dec[i]);
                  if (cnt[i] == `TCT_ONE) begin
                    cnt_out[i] <= 1'b1;
                  end
                end
              end
              `TCT_PAT_SHOT: begin
                cnt[i] <= tct_dec1(cnt[i], dec[i]);
                if (cnt[i] == `TCT_ONE) begin
                  cnt_out[i] <= 1'b1;
                  run[i] <= 1'b0;
                end
              end
              `TCT_PAT_RATE: begin
                if (!s_gate[i]) begin
                  cnt_out[i] <= 1'b1;
                end else if (cnt[i] == `TCT_ONE) begin
                  cnt[i] <= reload[i];
                  cnt_out[i] <= 1'b1;
                end else begin
                  cnt[i] <= tct_dec1(cnt[i], dec[i]);
                  cnt_out[i] <= cnt[i] != `TCT_TWO;
                end
              end
              `TCT_PAT_SQUARE: begin
                // odd counts: minus one high, minus three low
                if (!s_gate[i]) begin
                  cnt_out[i] <= 1'b1;
                end else if (cnt[i] == `TCT_TWO || cnt[i] == `TCT_ONE) begin
                  cnt[i] <= reload[i];
                  cnt_out[i] <= !cnt_out[i];
                end else if (cnt[i][0]) begin
                  cnt[i] <= tct_decn(cnt[i], dec[i], cnt_out[i] ? 2'h1 : 2'h3);
                end else begin
                  cnt[i] <= tct_decn(cnt[i], dec[i], 2'h2);
                end
              end
              default: begin
                // Strobe patterns: one clock low at terminal count.
                if (!cnt_out[i]) begin
                  cnt_out[i] <= 1'b1;
                  run[i] <= 1'b0;
                end else if (s_gate[i] || pat[i] == `TCT_PAT_HSTROBE) begin
                  cnt[i] <= tct_dec1(cnt[i], dec[i]);
                  cnt_out[i] <= cnt[i] != `TCT_ONE;
                end
              end
            endcase
          end
        end
      end
    end
  end

endmodule // tct_timer

// ==== testbench/tct_cpu_model.sv ====
/*
  Processor model for the timer port: programmed write and read cycles.
  Assumes a 20 MHz clk; strobes are far longer than the port sync delay.
*/
`timescale 1ns/100ps
module tct_cpu_model (
  // Clock.
  input wire clk,
  // Bus pins.
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_select_lo,
  output logic port_select_hi,
  output wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire data_oe_n
);
  logic drv;
  logic [7:0] wdat;
  // Resolved data wire; an undriven bus shows the inverse of the last byte.
  assign data_in = !data_oe_n ? data_out : drv ? wdat : ~wdat;
  // Bus idle at time zero.
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    {port_select_hi, port_select_lo} = 2'h0;
    drv = 1'b0;
    wdat = 8'h00;
  end
  // One access; the byte read is taken at the last edge of the strobe.
  task automatic cycle(input logic [1:0] p, input logic sel, input logic wr,
    input logic [7:0] w, output logic [7:0] r);
    @(posedge clk) #5;
    {port_select_hi, port_select_lo} = p;
    cs_n = !sel;
    wdat = w;
    drv = wr;
    @(posedge clk) #5;
    if (wr) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (8) @(posedge clk);
    r = data_in;
    #5;
    {rd_n, wr_n} = 2'h3;
    @(posedge clk) #5;
    {cs_n, drv} = 2'h2;
    repeat (20) @(posedge clk);
  endtask
endmodule // tct_cpu_model

// ==== testbench/tct_timer_props.sv ====
/*
  Checker for the interval timer port: data pin float and drive timing and
  channel output stability. Assumes it is bound to tct_timer.
*/
`timescale 1ns/100ps
module tct_timer_props (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Processor port.
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire port_select_lo,
  input wire port_select_hi,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire data_oe_n,
  // Channel pins.
  input wire [2:0] cnt_clk,
  input wire [2:0] cnt_gate,
  input wire [2:0] cnt_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [3:0] quiet;
  reg [6:0] pins_q;
  // A read of a channel as seen at the pins.
  wire rdc = !cs_n && !rd_n && wr_n && !(port_select_hi && port_select_lo);
  // Counts cycles since a channel clock or gate pin or the write strobe last moved.
  always @(posedge clk) begin
    pins_q <= {cnt_clk, cnt_gate, wr_n};
    if (sys_rst || pins_q != {cnt_clk, cnt_gate, wr_n}) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end
  a_desel_float: assert property (cs_n [*5] |-> data_oe_n)
    else $error("data pin driven while deselected");
  a_setup_noread: assert property ((port_select_hi && port_select_lo) [*5] |-> data_oe_n)
    else $error("data pin driven at setup port");
  a_idle_float: assert property (rd_n [*5] |-> data_oe_n)
    else $error("data pin driven without read");
  a_write_float: assert property ((!wr_n) [*5] |-> data_oe_n)
    else $error("data pin driven during write");
  a_read_drive: assert property (rdc [*4] |-> !data_oe_n)
    else $error("channel read not answered");
  a_drive_cause: assert property ($fell(data_oe_n) |-> $past(rdc, 3))
    else $error("data pin driven without cause");
  a_release_cause: assert property ($rose(data_oe_n) |-> !$past(rdc, 3))
    else $error("data pin released during read");
  a_out_quiet: assert property (quiet > 4'h6 |-> $stable(cnt_out))
    else $error("channel output moved without cause");
  c_read: cover property (rdc [*4]);
  c_out_rise: cover property ($rose(cnt_out[0]));
  c_setup: cover property (!cs_n && port_select_hi && port_select_lo && $rose(wr_n));
endmodule // tct_timer_props

bind tct_timer tct_timer_props u_props (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .port_select_lo(port_select_lo),
  .port_select_hi(port_select_hi), .data_in(data_in), .data_out(data_out),
  .data_oe_n(data_oe_n), .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));

// ==== testbench/test_three_channel_interval_timer.sv ====
/*
  Self-checking bench for the interval timer: setup words, loads, reads,
  latching, decimal counting and refused accesses. Assumes tct_cpu_model.
*/
`timescale 1ns/100ps
module test_three_channel_interval_timer;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] cnt_clk = 3'h0;
  logic [2:0] cnt_gate = 3'h7;
  wire cs_n, rd_n, wr_n, port_select_lo, port_select_hi, data_oe_n;
  wire [7:0] data_in, data_out;
  wire [2:0] cnt_out;
  logic [7:0] v0, v1, w0, w1;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int ph = 0;
  tct_timer dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_lo(port_select_lo), .port_select_hi(port_select_hi),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));
  tct_cpu_model cpu (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_lo(port_select_lo), .port_select_hi(port_select_hi),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
  // Clock at 20 MHz.
  initial begin
    forever #25 clk = ~clk;
  end
  // Channel clocks toggle every ten cycles; a cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ph <= (ph == 9) ? 0 : ph + 1;
    if (ph == 9) cnt_clk <= #5 ~cnt_clk;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  task automatic put(input logic [1:0] p, input logic [7:0] w, input logic sel = 1'b1);
    logic [7:0] r;
    cpu.cycle(p, sel, 1'b1, w, r);
  endtask
  task automatic get(input logic [1:0] p, output logic [7:0] r);
    cpu.cycle(p, 1'b1, 1'b0, 8'h00, r);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  // Counts low samples of channel 1 over eight channel clock periods.
  task automatic lows(output logic [7:0] n);
    n = 8'h00;
    repeat (8) begin
      repeat (20) @(posedge clk);
      n = n + {7'h00, !cnt_out[1]};
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence; every channel gets its setup word before its count.
  initial begin
    repeat (16) @(posedge clk);
    #5 sys_rst = 1'b0;
    put(2'h3, 8'h30);
    chkb("out0 after setup", 1'b0, cnt_out[0]);
    put(2'h0, 8'h05);
    put(2'h0, 8'h00);
    chkb("out0 counting", 1'b0, cnt_out[0]);
    repeat (200) @(posedge clk);
    chkb("out0 terminal", 1'b1, cnt_out[0]);
    put(2'h3, 8'h30, 1'b0);
    put(2'h3, 8'hF0);
    chkb("out0 kept", 1'b1, cnt_out[0]);
    get(2'h3, v0);
    chk("setup read floats", 8'hFF, v0);
    put(2'h3, 8'h5C);
    put(2'h1, 8'h04);
    repeat (100) @(posedge clk);
    lows(v0);
    chk("rate lows", 8'h02, v0);
    #5 cnt_gate[1] = 1'b0;
    lows(v0);
    chk("gated lows", 8'h00, v0);
    #5 cnt_gate[1] = 1'b1;
    put(2'h3, 8'h56);
    put(2'h1, 8'h04);
    repeat (100) @(posedge clk);
    lows(v0);
    chk("square lows", 8'h04, v0);
    put(2'h3, 8'h52);
    put(2'h1, 8'h03);
    repeat (100) @(posedge clk);
    #5 cnt_gate[1] = 1'b0;
    repeat (40) @(posedge clk);
    #5 cnt_gate[1] = 1'b1;
    lows(v0);
    chk("one shot lows", 8'h03, v0);
    put(2'h3, 8'hB1);
    put(2'h2, 8'h10);
    put(2'h2, 8'h00);
    repeat (3) begin
      get(2'h2, v0);
      get(2'h2, v1);
      chkb("bcd digits", 1'b1, v0[3:0] < 4'hA && v0[7:4] < 4'hA
        && v1[3:0] < 4'hA && v1[7:4] < 4'hA);
    end
    put(2'h3, 8'h80);
    repeat (400) @(posedge clk);
    get(2'h2, v0);
    get(2'h2, v1);
    get(2'h2, w0);
    get(2'h2, w1);
    chkb("latch frozen", 1'b1, {v1, v0} !== {w1, w0});
    put(2'h3, 8'h20);
    put(2'h0, 8'h02);
    repeat (100) @(posedge clk);
    get(2'h0, v0);
    chk("upper only", 8'h01, v0);
    close_out();
  end
endmodule // test_three_channel_interval_timer
